// ===== rtl/ids_map.svh
/*
  Register offsets, field positions, reset values and counts of the
  I2C data path, own-address match and START filter.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef IDS_MAP_SVH
`define IDS_MAP_SVH

// Register offsets on the special function register bus
`define IDS_OFS_START_SAMPLE_SETUP 8'hDB
`define IDS_OFS_SHIFT_DATA 8'hDE
`define IDS_OFS_OWN_SLAVE_ADDRESS 8'hDF

// Reset values
`define IDS_RST_START_SAMPLE_SETUP 8'h00
`define IDS_RST_SHIFT_DATA 8'h00
`define IDS_RST_OWN_SLAVE_ADDRESS 8'h00

// Field positions
`define IDS_SETUP_EN_BIT 7
`define IDS_SETUP_CNT_MSB 6
`define IDS_SETUP_CNT_LSB 0
`define IDS_ADDR_MSB 7
`define IDS_ADDR_LSB 1

// Counts
`define IDS_BYTE_BITS 4'h8
`define IDS_ACK_BITS 4'h9
`define IDS_SINGLE_SAMPLE 8'h01

// Minimum START hold times in ns, for firmware sizing of the count
`define IDS_START_HOLD_MIN_STD_NS 4000
`define IDS_START_HOLD_MIN_FAST_NS 600
`define IDS_START_HOLD_MIN_HS_NS 160

`endif

// ===== rtl/ids_pkg.sv
/*
  Types of the I2C data path, own-address match and START filter.
  Assumes no surroundings beyond the design files that import it.
*/
package ids_pkg;

  // Engine states on the link side
  typedef enum logic [2:0] {
    IDS_IDLE,
    IDS_FILT,
    IDS_ADDR,
    IDS_WAIT,
    IDS_DATA
  } ids_state_t;

  // Start filter setup and own address as held on the link side
  typedef struct packed {
    logic en;
    logic [6:0] cnt;
    logic [6:0] addr;
  } ids_cfg_t;

  // Byte handed from the link side to the register side
  typedef struct packed {
    logic match;
    logic [7:0] data;
  } ids_byte_t;

endpackage

// ===== rtl/ids_sync.sv
/*
  Three flip-flop synchroniser for one bit.
  Assumes d comes from another clock domain or a pin; q2 is the
  synchronised level, q3 one stage later for agreement or edges.
*/
`timescale 1ns/1ps
module ids_sync import ids_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q2,
  output logic q3
);

  logic q1_reg;

  // Chain of three stages; only q2 reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1_reg <= 1'b0;
      q2 <= 1'b0;
      q3 <= 1'b0;
    end else begin
      q1_reg <= d;
      q2 <= q1_reg;
      q3 <= q2;
    end
  end

endmodule

// ===== rtl/ids_top.sv
/*
  I2C byte shift engine with own-address match and START sampling filter.
  Registers on clk behind the special function register port; bus-facing
  logic on osc_clk, the free-running sampling oscillator. Assumes the
  controller supplies mode levels and owns the transfer flag and ack.
*/
`timescale 1ns/1ps
`include "ids_map.svh"
module ids_top import ids_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic slave_mode,
  input wire logic tx_mode,
  output logic xfer_int_set,
  output logic addr_match_set,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // Register side state
  logic [7:0] setup_reg;
  logic [7:0] data_reg;
  logic [6:0] own_addr_reg;
  logic pending_reg;
  logic rel_tgl_reg;
  logic cfg_tgl_reg;

  // Link side state
  ids_state_t state_reg;
  ids_cfg_t cfg_reg;
  ids_byte_t byte_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] left_reg;
  logic tx_l_reg;
  logic done_tgl_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_p_reg;
  logic sda_p_reg;

  // Synchroniser outputs
  logic scl_q2, scl_q3, sda_q2, sda_q3;
  logic slv_q2, slv_q3, txm_q2, txm_q3;
  logic rel_q2, rel_q3, cfg_q2, cfg_q3;
  logic done_q2, done_q3;

  logic wr_data, rd_data, done_ev;
  logic rel_ev, cfg_ev, start_edge, stop_edge, scl_rise, scl_fall;

  // Sample count for a START: one when disabled, else field plus one
  function automatic logic [7:0] sample_count(input ids_cfg_t c);
    if (c.en) begin
      sample_count = {1'b0, c.cnt} + 8'h01;
    end else begin
      sample_count = `IDS_SINGLE_SAMPLE;
    end
  endfunction

  // Register side decode
  assign wr_data = sfr_wr && (sfr_addr == `IDS_OFS_SHIFT_DATA);
  assign rd_data = sfr_rd && (sfr_addr == `IDS_OFS_SHIFT_DATA);
  assign done_ev = done_q2 ^ done_q3;

  // Pins into the oscillator domain, inverted so the chain's reset level
  // matches an idle, high line and no false edge follows reset
  ids_sync u_scl_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(~scl_in),
    .q2(scl_q2),
    .q3(scl_q3)
  );

  ids_sync u_sda_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(~sda_in),
    .q2(sda_q2),
    .q3(sda_q3)
  );

  // Mode levels and register-side events into the oscillator domain
  ids_sync u_slv_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(slave_mode),
    .q2(slv_q2),
    .q3(slv_q3)
  );

  ids_sync u_txm_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(tx_mode),
    .q2(txm_q2),
    .q3(txm_q3)
  );

  ids_sync u_rel_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(rel_tgl_reg),
    .q2(rel_q2),
    .q3(rel_q3)
  );

  ids_sync u_cfg_sync (
    .clk(osc_clk),
    .rst_n(rst_n),
    .d(cfg_tgl_reg),
    .q2(cfg_q2),
    .q3(cfg_q3)
  );

  // Byte-done event back into the register domain
  ids_sync u_done_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(done_tgl_reg),
    .q2(done_q2),
    .q3(done_q3)
  );

  // Setup and own address; the engine never writes them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg <= `IDS_RST_START_SAMPLE_SETUP;
      own_addr_reg <= 7'h00;
      cfg_tgl_reg <= 1'b0;
    end else if (sfr_wr && (sfr_addr == `IDS_OFS_START_SAMPLE_SETUP)) begin
      setup_reg <= sfr_wdata;
      cfg_tgl_reg <= ~cfg_tgl_reg;
    end else if (sfr_wr && (sfr_addr == `IDS_OFS_OWN_SLAVE_ADDRESS)) begin
      own_addr_reg <= sfr_wdata[`IDS_ADDR_MSB:`IDS_ADDR_LSB];
      cfg_tgl_reg <= ~cfg_tgl_reg;
    end
  end

  // Shift data: received byte lands on done, software writes otherwise
  // Set wins: a byte landing beats a write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= `IDS_RST_SHIFT_DATA;
    end else if (done_ev && (byte_reg.match || !tx_mode)) begin
      data_reg <= byte_reg.data;
    end else if (wr_data) begin
      data_reg <= sfr_wdata;
    end
  end

  // Stall bookkeeping: write releases in transmit, read in receive
  // A release is only honoured while a byte is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
      rel_tgl_reg <= 1'b0;
    end else if (done_ev) begin
      pending_reg <= 1'b1;
    end else if (pending_reg && ((wr_data && tx_mode) || (rd_data && !tx_mode))) begin
      pending_reg <= 1'b0;
      rel_tgl_reg <= ~rel_tgl_reg;
    end
  end

  // Event pulses to the controller's flag and match bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_int_set <= 1'b0;
      addr_match_set <= 1'b0;
    end else begin
      xfer_int_set <= done_ev;
      addr_match_set <= done_ev && byte_reg.match;
    end
  end

  // Read data; unmapped offsets and address bit 0 read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `IDS_OFS_START_SAMPLE_SETUP: sfr_rdata <= setup_reg;
        `IDS_OFS_SHIFT_DATA: sfr_rdata <= data_reg;
        `IDS_OFS_OWN_SLAVE_ADDRESS: sfr_rdata <= {own_addr_reg, 1'b0};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Oscillator-domain events and line edges
  assign rel_ev = rel_q2 ^ rel_q3;
  assign cfg_ev = cfg_q2 ^ cfg_q3;
  assign start_edge = scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg;
  assign stop_edge = scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg;
  assign scl_rise = scl_f_reg && !scl_p_reg;
  assign scl_fall = !scl_f_reg && scl_p_reg;

  // Line filter: a change counts once the last two stages agree
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      if (scl_q2 == scl_q3) begin
        scl_f_reg <= !scl_q2;
      end
      if (sda_q2 == sda_q3) begin
        sda_f_reg <= !sda_q2;
      end
      scl_p_reg <= scl_f_reg;
      sda_p_reg <= sda_f_reg;
    end
  end

  // Setup copy, taken when a register write has crossed
  // Own address is copied too; only the slave compare reads it
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= '0;
    end else if (cfg_ev) begin
      cfg_reg.en <= setup_reg[`IDS_SETUP_EN_BIT];
      cfg_reg.cnt <= setup_reg[`IDS_SETUP_CNT_MSB:`IDS_SETUP_CNT_LSB];
      cfg_reg.addr <= own_addr_reg;
    end
  end

  // Byte engine: START filter, address compare, shifting and stall
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDS_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      left_reg <= 8'h00;
      tx_l_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
      byte_reg <= '0;
      scl_oe <= 1'b0;
    end else if (start_edge) begin
      scl_oe <= 1'b0;
      bit_cnt_reg <= 4'h0;
      if (slv_q2) begin
        // Slave: validate the START before taking the address
        left_reg <= sample_count(cfg_reg);
        state_reg <= IDS_FILT;
      end else begin
        // Master: shift straight from shift data, own address unused
        tx_l_reg <= txm_q2;
        shift_reg <= data_reg;
        state_reg <= IDS_DATA;
      end
    end else if (stop_edge) begin
      scl_oe <= 1'b0;
      state_reg <= IDS_IDLE;
    end else begin
      case (state_reg)
        IDS_IDLE: begin
          scl_oe <= 1'b0;
        end
        IDS_FILT: begin
          // One sample per oscillator cycle, first two cycles after sda_f_reg falls
          if (sda_f_reg || !scl_f_reg) begin
            state_reg <= IDS_IDLE;
          end else if (left_reg == 8'h01) begin
            state_reg <= IDS_ADDR;
          end else begin
            left_reg <= left_reg - 8'h01;
          end
        end
        IDS_ADDR, IDS_DATA: begin
          if (scl_rise && bit_cnt_reg < `IDS_ACK_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg < `IDS_BYTE_BITS && !(state_reg == IDS_DATA && tx_l_reg)) begin
              shift_reg <= {shift_reg[6:0], sda_f_reg};
            end
          end else if (scl_fall && bit_cnt_reg == `IDS_ACK_BITS) begin
            if (state_reg == IDS_ADDR && shift_reg[7:1] != cfg_reg.addr) begin
              state_reg <= IDS_IDLE;
            end else begin
              byte_reg.data <= shift_reg;
              byte_reg.match <= (state_reg == IDS_ADDR);
              done_tgl_reg <= ~done_tgl_reg;
              scl_oe <= 1'b1;
              state_reg <= IDS_WAIT;
            end
          end else if (scl_fall && state_reg == IDS_DATA && tx_l_reg &&
                       bit_cnt_reg != 4'h0 && bit_cnt_reg < `IDS_BYTE_BITS) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        IDS_WAIT: begin
          // Hold SCL low until software has serviced the byte
          if (rel_ev) begin
            scl_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            tx_l_reg <= txm_q2;
            shift_reg <= data_reg;
            state_reg <= IDS_DATA;
          end
        end
        default: begin
          state_reg <= IDS_IDLE;
        end
      endcase
    end
  end

  // Transmit drive: pull SDA low for a zero bit, never in the ack slot
  // SDA only moves while SCL is low, else peers would see START or STOP
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else if (state_reg != IDS_DATA || !tx_l_reg) begin
      sda_oe <= 1'b0;
    end else if (!scl_f_reg) begin
      sda_oe <= (bit_cnt_reg < `IDS_BYTE_BITS) && !shift_reg[7];
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule

// ===== testbench/i2c_data_addr_start_filter_tb.sv
/*
  Testbench: register access, START filter counts, receive and transmit.
  Assumes ids_top with the bus model as master on pulled-up lines.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module i2c_data_addr_start_filter_tb;
  logic clk, rst_n, osc_clk, sfr_wr, sfr_rd, slave_mode, tx_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, rb;
  logic xfer_int_set, addr_match_set, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
  int errors = 0, compares = 0, ev_cnt = 0, m_cnt = 0, e0, m0;
  logic [7:0] cs [6] = '{8'h00, 8'h85, 8'hFF, 8'h8B, 8'hFF, 8'h00};
  logic [7:0] ca [6] = '{8'hB4, 8'hB4, 8'hB4, 8'hB4, 8'hB4, 8'h66};
  int ch [6] = '{8, 20, 20, 8, 140, 8};
  int ce [6] = '{1, 1, 0, 0, 1, 0};
  wire scl_line = !(scl_oe && !scl_out) && !m_scl;
  wire sda_line = !(sda_oe && !sda_out) && !m_sda;
  ids_top dut (
    .clk(clk), .rst_n(rst_n), .osc_clk(osc_clk), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .slave_mode(slave_mode), .tx_mode(tx_mode), .xfer_int_set(xfer_int_set),
    .addr_match_set(addr_match_set), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  ids_bus_model bm (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(m_scl),
    .sda_pull(m_sda));
  // Clocks, the oscillator out of phase with clk
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #24 osc_clk = ~osc_clk;
  end
  // Count event pulses
  always @(posedge clk) begin
    if (xfer_int_set === 1'b1) ev_cnt++;
    if (addr_match_set === 1'b1) m_cnt++;
  end
  // One register bus cycle, entered and left at a falling edge
  task automatic acc(input logic w, r, input logic [7:0] a, wd);
    sfr_wr = w;
    sfr_rd = r;
    sfr_addr = a;
    sfr_wdata = wd;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, wd);
    acc(1'b1, 1'b0, a, wd);
    acc(1'b0, 1'b0, a, wd);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] rd_d);
    acc(1'b0, 1'b1, a, 8'h00);
    rd_d = sfr_rdata;
    acc(1'b0, 1'b0, a, 8'h00);
  endtask
  // Wait for a new event pulse, bounded
  task automatic wait_ev();
    int n;
    n = 0;
    while (ev_cnt == e0 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500000;
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_n, sfr_wr, sfr_rd, slave_mode, tx_mode} = 5'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (25) @(negedge clk);
    rd(8'hDB, d); `CHK(d, 8'h00)
    rd(8'hDE, d); `CHK(d, 8'h00)
    rd(8'hDF, d); `CHK(d, 8'h00)
    acc(1'b1, 1'b0, 8'hDB, 8'hA5); rd(8'hDB, d); `CHK(d, 8'hA5)
    acc(1'b1, 1'b0, 8'hDF, 8'hFF); rd(8'hDF, d); `CHK(d, 8'hFE)
    acc(1'b1, 1'b0, 8'h10, 8'hFF); rd(8'h10, d); `CHK(d, 8'h00)
    wr(8'hDE, 8'h5C); rd(8'hDE, d); `CHK(d, 8'h5C)
    wr(8'hDF, 8'hB4);
    slave_mode = 1'b1;
    for (int k = 0; k < 6; k++) begin
      wr(8'hDB, cs[k]);
      repeat (50) @(negedge clk);
      e0 = ev_cnt;
      m0 = m_cnt;
      bm.start(ch[k] * 48);
      bm.xfer(ca[k], rb);
      wait_ev();
      `CHK(ev_cnt - e0, ce[k])
      `CHK(m_cnt - m0, ce[k])
      if (ce[k] == 1) begin
        `CHK(scl_oe, 1'b1)
        rd(8'hDE, d); `CHK(d, ca[k])
        e0 = ev_cnt;
        bm.xfer(8'h3C, rb);
        wait_ev();
        rd(8'hDE, d); `CHK(d, 8'h3C)
      end
      bm.stop();
      @(negedge clk);
    end
    e0 = ev_cnt;
    bm.start(400);
    bm.xfer(8'hB5, rb);
    wait_ev();
    `CHK(ev_cnt - e0, 1)
    tx_mode = 1'b1;
    repeat (20) @(negedge clk);
    e0 = ev_cnt;
    wr(8'hDE, 8'h96);
    bm.xfer(8'hFF, rb); `CHK(rb, 8'h96)
    wait_ev();
    `CHK(ev_cnt - e0, 1)
    `CHK(sda_out, 1'b0)
    wr(8'hDE, 8'hFF);
    bm.stop();
    @(negedge clk);
    `CHK(sda_oe, 1'b0)
    {tx_mode, slave_mode} = 2'b00;
    repeat (20) @(negedge clk);
    {e0, m0} = {ev_cnt, m_cnt};
    bm.start(400);
    bm.xfer(8'h66, rb);
    wait_ev();
    `CHK(ev_cnt - e0, 1)
    `CHK(m_cnt - m0, 0)
    rd(8'hDE, d); `CHK(d, 8'h66)
    bm.stop();
    @(negedge clk);
    rd(8'hDF, d); `CHK(d, 8'hB4)
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (25) @(negedge clk);
    rd(8'hDF, d); `CHK(d, 8'h00)
    rd(8'hDE, d); `CHK(d, 8'h00)
    end_sim();
  end
endmodule

// ===== testbench/ids_bus_model.sv
/*
  Bus master model: START, nine-clock bytes, STOP, honouring stretch.
  Assumes open-drain lines with pull-ups resolved by the bench.
*/
`timescale 1ns/1ps
module ids_bus_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  localparam int Q = 250;
  // Bus idle: both lines released
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Release SCL and wait while the slave stretches it
  task automatic scl_high();
    int n;
    scl_pull = 1'b0;
    n = 0;
    while (!scl_line && n < 4000) begin
      #10;
      n++;
    end
    #Q;
  endtask
  // START held for hold_ns with SCL high
  task automatic start(input int hold_ns);
    sda_pull = 1'b1;
    #hold_ns;
    scl_pull = 1'b1;
    #Q;
  endtask
  // Eight bits MSB first plus a released ack slot
  task automatic xfer(input logic [7:0] b, output logic [7:0] rb);
    for (int i = 7; i >= -1; i--) begin
      #Q;
      sda_pull = (i >= 0) ? ~b[i] : 1'b0;
      #Q;
      scl_high();
      if (i >= 0) rb[i] = sda_line;
      scl_pull = 1'b1;
    end
  endtask
  // STOP: SDA rises with SCL high
  task automatic stop();
    sda_pull = 1'b1;
    #Q;
    scl_high();
    sda_pull = 1'b0;
    #Q;
  endtask
endmodule

// ===== testbench/ids_checker.sv
/*
  Port checker for ids_top: register reads, event pulses, SCL stall.
  Assumes the bind below; only the clk domain is watched.
*/
`timescale 1ns/1ps
module ids_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic slave_mode,
  input wire logic xfer_int_set,
  input wire logic addr_match_set,
  input wire logic scl_out,
  input wire logic scl_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] quiet_reg;
  // Cycles since the last shift data access, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet_reg <= 6'h3F;
    else if ((sfr_rd || sfr_wr) && sfr_addr == 8'hDE) quiet_reg <= 6'h00;
    else if (quiet_reg != 6'h3F) quiet_reg <= quiet_reg + 6'h01;
  end
  a_unmapped_zero: assert property (sfr_rd && !(sfr_addr inside {8'hDB, 8'hDE, 8'hDF})
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  a_setup_back: assert property (sfr_wr && sfr_addr == 8'hDB ##1 sfr_rd && sfr_addr == 8'hDB
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("setup readback");
  a_addr_back: assert property (sfr_wr && sfr_addr == 8'hDF ##1 sfr_rd && sfr_addr == 8'hDF
    |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'hFE)) else $error("own address readback");
  a_int_pulse: assert property (xfer_int_set |=> !xfer_int_set)
    else $error("event pulse too long");
  a_match_pair: assert property (addr_match_set |-> xfer_int_set && slave_mode)
    else $error("match without event or in master mode");
  a_stall_on_int: assert property (xfer_int_set |-> scl_oe && !scl_out)
    else $error("event without SCL stall");
  a_release_cause: assert property ($fell(scl_oe) |-> quiet_reg < 6'h28)
    else $error("SCL released without shift data access");
  c_event: cover property (xfer_int_set);
  c_match: cover property (addr_match_set);
  c_release: cover property ($fell(scl_oe));
endmodule
bind ids_top ids_checker chk (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .slave_mode(slave_mode),
  .xfer_int_set(xfer_int_set), .addr_match_set(addr_match_set),
  .scl_out(scl_out), .scl_oe(scl_oe)
);
